// [rtl/ipe_encap.sv]
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// Byte FIFO, power-of-two depth
module ipe_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic [WIDTH-1:0] in_data_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  output logic [WIDTH-1:0] out_data_out,
  output logic out_valid_out,
  input wire logic out_ready_in
);
  localparam int AW = $clog2(DEPTH);
  // Pointers and fill level
  typedef struct packed {
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
  } ipe_fifo_st_t;
  ipe_fifo_st_t s_q, s_d;
  logic [WIDTH-1:0] mem_q [DEPTH]; // Storage, no reset needed
  logic push;
  logic pop;

  // Honest full and empty from the count
  assign in_ready_out = (s_q.cnt != (AW+1)'(DEPTH));
  assign out_valid_out = (s_q.cnt != '0);
  assign out_data_out = mem_q[s_q.rd];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;

  // Next pointer values
  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.wr = s_q.wr + AW'(1);
    end
    if (pop) begin
      s_d.rd = s_q.rd + AW'(1);
    end
    s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  // State register
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Write port
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem_q[s_q.wr] <= in_data_in;
    end
  end
endmodule // ipe_fifo

// ==========================================================
// Encapsulator top
module ipe_encap
  import ipe_pkg::*;
#(
  parameter logic [10:0] MIN_DATA_3M = 11'h02E, // Slow link minimum data field
  parameter int FIFO_DEPTH = 16
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic variant_in, // 0 fast, 1 slow link, held static
  input wire logic [47:0] own_mac_in,
  input wire logic [31:0] own_ip_in,
  input wire logic [31:0] host_mask_in,
  input wire logic [31:0] tx_dst_ip_in,
  input wire logic [47:0] tx_dst_mac_in,
  input wire logic [7:0] tx_data_in,
  input wire logic tx_valid_in,
  input wire logic tx_last_in,
  output logic tx_ready_out,
  output logic [7:0] mac_tx_data_out,
  output logic mac_tx_valid_out,
  output logic mac_tx_last_out,
  output logic mac_tx_abort_out,
  input wire logic mac_tx_ready_in,
  input wire logic [7:0] mac_rx_data_in,
  input wire logic mac_rx_valid_in,
  input wire logic mac_rx_last_in,
  output logic [7:0] rx_data_out,
  output logic rx_valid_out,
  output logic rx_last_out,
  output logic rx_drop_out,
  output logic tx_oversize_out,
  output logic arp_seen_out
);
  // ==========================================================
  // State of the whole block
  typedef struct packed {
    ipe_tx_t tx;
    logic [10:0] tidx, tcnt; // Header or reply byte index, data octets sent
    logic [7:0] od; // Byte in the output stage
    logic ov, ol, oa, oerr; // Stage valid, last, abort, oversize pulse
    ipe_rx_t rx;
    logic [10:0] ridx;
    logic [15:0] rtype, rtlen; // Type being gathered, IP total length
    logic [7:0] rd; // Delivered byte
    logic rv, rl, rdrop; // Delivery valid, last, drop pulse
    logic [15:0] aop;
    logic [47:0] asha;
    logic [31:0] aspa, atpa; // Querier and target Internet addresses
    logic apend, aseen; // Reply owed to a querier, query pulse
  } ipe_st_t;
  ipe_st_t s_q, s_d;
  logic f_valid, f_pop; // FIFO has a byte, byte taken from it
  logic [8:0] f_word; // {last, data}
  logic adv; // Output stage free this cycle
  logic slow, bcast; // Variant select, broadcast destination
  logic [10:0] hlen, minlen, maxlen; // Figures of the chosen variant
  logic [15:0] iptype, tlen_now, type_now;
  logic [7:0] d8;
  logic [47:0] dmac;
  logic [111:0] hdr10, hsh10; // Fast header and its shifted copy
  logic [31:0] hdr3, hsh3; // Slow header and its shifted copy
  logic [479:0] arpf, ash; // Reply frame and its shifted copy
  logic arp_set, arp_done;
  // ==========================================================
  // Host side buffer; its ready is the host back-pressure
  ipe_fifo #(
    .WIDTH(9),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .in_data_in({tx_last_in, tx_data_in}),
    .in_valid_in(tx_valid_in),
    .in_ready_out(tx_ready_out),
    .out_data_out(f_word),
    .out_valid_out(f_valid),
    .out_ready_in(f_pop)
  );

  // ==========================================================
  // Variant dependent figures
  assign slow = variant_in;
  assign hlen = slow ? IPE_HDR_3M : IPE_HDR_10M;
  assign minlen = slow ? MIN_DATA_3M : IPE_MIN_DATA_10M;
  assign maxlen = slow ? IPE_MAX_DG_3M : IPE_MAX_DG_10M;
  assign iptype = slow ? IPE_TYPE_IP_3M : IPE_TYPE_IP_10M;
  // Broadcast when the host part is all ones
  assign bcast = ((tx_dst_ip_in & host_mask_in) == host_mask_in);
  assign dmac = bcast ? IPE_BCAST_10M : tx_dst_mac_in;
  // Low host byte; broadcast to zero
  assign d8 = bcast ? IPE_BCAST_3M : (tx_dst_ip_in[7:0] & host_mask_in[7:0]);
  assign hdr3 = {d8, own_mac_in[7:0], IPE_TYPE_IP_3M};
  assign hdr10 = {dmac, own_mac_in, IPE_TYPE_IP_10M};
  // Reply frame, zero padded to minimum
  assign arpf = {s_q.asha, own_mac_in, IPE_TYPE_ARP, IPE_ARP_HRD_ETH, IPE_TYPE_IP_10M,
                 IPE_ARP_HLN, IPE_ARP_PLN, IPE_ARP_OP_REP, own_mac_in, own_ip_in,
                 s_q.asha, s_q.aspa, 144'h0};
  // High byte first on the wire
  assign hsh10 = hdr10 << {s_q.tidx, 3'b000};
  assign hsh3 = hdr3 << {s_q.tidx, 3'b000};
  assign ash = arpf << {s_q.tidx, 3'b000};
  // Output stage may load when empty or taken
  assign adv = !s_q.ov || mac_tx_ready_in;
  // ==========================================================
  // Next state for transmit and receive
  always_comb begin
    s_d = s_q;
    f_pop = 1'b0;
    arp_set = 1'b0;
    arp_done = 1'b0;
    tlen_now = s_q.rtlen;
    type_now = {s_q.rtype[7:0], mac_rx_data_in};
    s_d.oerr = 1'b0;
    s_d.rdrop = 1'b0;
    s_d.aseen = 1'b0;
    s_d.rv = 1'b0;
    s_d.rl = 1'b0;
    // Taken byte leaves the stage
    if (adv) begin
      s_d.ov = 1'b0;
      s_d.ol = 1'b0;
      s_d.oa = 1'b0;
    end
    // Only plain framing, trailers never built
    unique case (s_q.tx)
      TX_IDLE: begin
        // Reply first, so a querier is not starved
        if (s_q.apend && !slow) begin
          s_d.tx = TX_ARP;
          s_d.tidx = '0;
        end else if (f_valid) begin
          s_d.tx = TX_HDR;
          s_d.tidx = '0;
          s_d.tcnt = '0;
        end
      end
      TX_HDR: begin
        if (adv) begin
          s_d.ov = 1'b1;
          s_d.od = slow ? hsh3[31:24] : hsh10[111:104];
          s_d.tidx = s_q.tidx + 11'h001;
          if (s_q.tidx == hlen - 11'h001) begin
            s_d.tx = TX_DATA;
          end
        end
      end
      TX_DATA: begin
        if (adv && f_valid) begin
          f_pop = 1'b1;
          s_d.ov = 1'b1;
          s_d.tcnt = s_q.tcnt + 11'h001;
          // Oversize aborts and is flagged for fragmenting
          if (s_q.tcnt == maxlen) begin
            s_d.od = 8'h00;
            s_d.ol = 1'b1;
            s_d.oa = 1'b1;
            s_d.oerr = 1'b1;
            s_d.tx = f_word[8] ? TX_IDLE : TX_FLUSH;
          end else begin
            s_d.od = f_word[7:0];
            if (f_word[8]) begin
              // Short datagrams padded on either link
              if (s_q.tcnt + 11'h001 < minlen) begin
                s_d.tx = TX_PAD;
              end else begin
                s_d.ol = 1'b1;
                s_d.tx = TX_IDLE;
              end
            end
          end
        end
      end
      TX_PAD: begin
        if (adv) begin
          s_d.ov = 1'b1;
          s_d.od = 8'h00;
          s_d.tcnt = s_q.tcnt + 11'h001;
          if (s_q.tcnt + 11'h001 == minlen) begin
            s_d.ol = 1'b1;
            s_d.tx = TX_IDLE;
          end
        end
      end
      TX_ARP: begin
        if (adv) begin
          s_d.ov = 1'b1;
          s_d.od = ash[479:472];
          s_d.tidx = s_q.tidx + 11'h001;
          if (s_q.tidx == IPE_ARP_LAST) begin
            s_d.ol = 1'b1;
            s_d.tx = TX_IDLE;
            arp_done = 1'b1;
          end
        end
      end
      TX_FLUSH: begin
        // Discard rest of an aborted datagram
        if (f_valid) begin
          f_pop = 1'b1;
          if (f_word[8]) begin
            s_d.tx = TX_IDLE;
          end
        end
      end
      default: begin
        s_d.tx = TX_IDLE;
      end
    endcase

    // Receive side, no back-pressure toward the link
    if (mac_rx_valid_in) begin
      s_d.ridx = s_q.ridx + 11'h001;
      unique case (s_q.rx)
        RX_HDR: begin
          s_d.rtype = type_now;
          if (s_q.ridx == hlen - 11'h001) begin
            s_d.ridx = '0;
            // Only matching type reaches IP side
            if (type_now == iptype) begin
              s_d.rx = RX_IP;
            end else if (type_now == IPE_TYPE_ARP && !slow) begin
              s_d.rx = RX_ARP;
            end else begin
              s_d.rdrop = 1'b1;
              s_d.rx = RX_SKIP;
            end
          end else if (mac_rx_last_in) begin
            s_d.rdrop = 1'b1;
          end
        end
        RX_IP: begin
          if (s_q.ridx == IPE_IP_TLEN_HI || s_q.ridx == IPE_IP_TLEN_LO) begin
            s_d.rtlen = {s_q.rtlen[7:0], mac_rx_data_in};
          end
          if (s_q.ridx == IPE_IP_TLEN_LO) begin
            tlen_now = {s_q.rtlen[7:0], mac_rx_data_in};
          end
          // Bytes past total length are pad, stripped
          if (s_q.ridx <= IPE_IP_TLEN_LO || {5'h00, s_q.ridx} < tlen_now) begin
            s_d.rv = 1'b1;
            s_d.rd = mac_rx_data_in;
            s_d.rl = mac_rx_last_in ||
                     (s_q.ridx >= IPE_IP_TLEN_LO && {5'h00, s_q.ridx} + 16'h0001 == tlen_now);
            if (s_d.rl) begin
              s_d.rx = RX_SKIP;
            end
          end
        end
        RX_ARP: begin
          // Gather opcode and addresses, high byte first
          if (s_q.ridx <= IPE_ARP_OP_LO) begin
            s_d.aop = {s_q.aop[7:0], mac_rx_data_in};
          end else if (s_q.ridx <= IPE_ARP_SHA_HI) begin
            s_d.asha = {s_q.asha[39:0], mac_rx_data_in};
          end else if (s_q.ridx <= IPE_ARP_SPA_HI) begin
            s_d.aspa = {s_q.aspa[23:0], mac_rx_data_in};
          end else if (s_q.ridx >= IPE_ARP_TPA_LO && s_q.ridx <= IPE_ARP_TPA_HI) begin
            s_d.atpa = {s_q.atpa[23:0], mac_rx_data_in};
          end
          // Query for our address owes a reply
          if (mac_rx_last_in && s_q.ridx >= IPE_ARP_TPA_HI &&
              s_d.aop == IPE_ARP_OP_REQ && s_d.atpa == own_ip_in) begin
            arp_set = 1'b1;
            s_d.aseen = 1'b1;
          end
        end
        RX_SKIP: begin
        end
      endcase
      // Frame end restarts header parsing
      if (mac_rx_last_in) begin
        s_d.rx = RX_HDR;
        s_d.ridx = '0;
      end
    end
    // New query wins over completion of the old reply
    s_d.apend = arp_set || (s_q.apend && !arp_done && !slow);
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  // Outputs straight from state flops
  assign {mac_tx_data_out, mac_tx_valid_out, mac_tx_last_out, mac_tx_abort_out, tx_oversize_out} =
         {s_q.od, s_q.ov, s_q.ol, s_q.oa, s_q.oerr};
  assign {rx_data_out, rx_valid_out, rx_last_out, rx_drop_out, arp_seen_out} =
         {s_q.rd, s_q.rv, s_q.rl, s_q.rdrop, s_q.aseen};
endmodule // ipe_encap
`default_nettype wire

// [rtl/ipe_pkg.sv]
package ipe_pkg;
  // ==========================================================
  // Frame constants
  localparam logic [15:0] IPE_TYPE_IP_10M = 16'h0800;
  localparam logic [15:0] IPE_TYPE_IP_3M = 16'h0201;
  localparam logic [15:0] IPE_TYPE_ARP = 16'h0806;
  localparam logic [15:0] IPE_ARP_HRD_ETH = 16'h0001;
  localparam logic [15:0] IPE_ARP_OP_REQ = 16'h0001;
  localparam logic [15:0] IPE_ARP_OP_REP = 16'h0002;
  localparam logic [7:0] IPE_ARP_HLN = 8'h06;
  localparam logic [7:0] IPE_ARP_PLN = 8'h04;
  localparam logic [47:0] IPE_BCAST_10M = 48'hFFFFFFFFFFFF;
  localparam logic [7:0] IPE_BCAST_3M = 8'h00;
  // ==========================================================
  // Lengths and byte positions
  localparam logic [10:0] IPE_MIN_DATA_10M = 11'h02E;
  localparam logic [10:0] IPE_MAX_DG_10M = 11'h5DC;
  localparam logic [10:0] IPE_MAX_DG_3M = 11'h600;
  localparam logic [10:0] IPE_HDR_10M = 11'h00E;
  localparam logic [10:0] IPE_HDR_3M = 11'h004;
  localparam logic [10:0] IPE_ARP_LAST = 11'h03B;
  localparam logic [10:0] IPE_IP_TLEN_HI = 11'h002;
  localparam logic [10:0] IPE_IP_TLEN_LO = 11'h003;
  localparam logic [10:0] IPE_ARP_OP_LO = 11'h007;
  localparam logic [10:0] IPE_ARP_SHA_HI = 11'h00D;
  localparam logic [10:0] IPE_ARP_SPA_HI = 11'h011;
  localparam logic [10:0] IPE_ARP_TPA_LO = 11'h018;
  localparam logic [10:0] IPE_ARP_TPA_HI = 11'h01B;
  // ==========================================================
  // States
  typedef enum logic [2:0] {
    TX_IDLE = 3'b000,
    TX_HDR = 3'b001,
    TX_DATA = 3'b010,
    TX_PAD = 3'b011,
    TX_ARP = 3'b100,
    TX_FLUSH = 3'b101
  } ipe_tx_t;
  typedef enum logic [1:0] {
    RX_HDR = 2'b00,
    RX_IP = 2'b01,
    RX_ARP = 2'b10,
    RX_SKIP = 2'b11
  } ipe_rx_t;
endpackage

// [testbench/ipe_encap_sva.sv]
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// Port checker for the encapsulator
module ipe_encap_chk
  import ipe_pkg::*;
#(
  parameter logic [10:0] MIN_DATA_3M = 11'h02E,
  parameter int FIFO_DEPTH = 16
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic variant_in,
  input wire logic [31:0] host_mask_in,
  input wire logic [31:0] tx_dst_ip_in,
  input wire logic [7:0] mac_tx_data_out,
  input wire logic mac_tx_valid_out,
  input wire logic mac_tx_last_out,
  input wire logic mac_tx_abort_out,
  input wire logic mac_tx_ready_in,
  input wire logic mac_rx_valid_in,
  input wire logic rx_valid_out,
  input wire logic rx_last_out,
  input wire logic rx_drop_out,
  input wire logic arp_seen_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  // Byte index inside the outgoing frame
  logic [10:0] pos_q;
  logic [10:0] lim_w;
  logic [10:0] min_w;
  logic bc_w;
  assign lim_w = variant_in ? 11'h604 : 11'h5EA;
  assign min_w = variant_in ? MIN_DATA_3M + 11'h003 : 11'h03B;
  assign bc_w = (tx_dst_ip_in & host_mask_in) == host_mask_in;
  always_ff @(posedge clk_in) begin
    if (!nrst_in) pos_q <= 11'h000;
    else if (mac_tx_valid_out && mac_tx_ready_in) pos_q <= mac_tx_last_out ? 11'h000 : pos_q + 11'h001;
  end
  sequence s_stall; mac_tx_valid_out && !mac_tx_ready_in; endsequence
  sequence s_held; mac_tx_valid_out && $stable(mac_tx_data_out) && $stable(mac_tx_last_out); endsequence
  property p_hold; s_stall |=> s_held; endproperty
  a_hold: assert property (p_hold) else $error("byte changed while stalled");
  property p_type_fast; mac_tx_valid_out && !variant_in && pos_q == 11'h00C |-> mac_tx_data_out == 8'h08; endproperty
  a_type_fast: assert property (p_type_fast) else $error("bad fast type");
  property p_type_slow; mac_tx_valid_out && variant_in && pos_q == 11'h003 |-> mac_tx_data_out == 8'h01; endproperty
  a_type_slow: assert property (p_type_slow) else $error("bad slow type");
  property p_min; mac_tx_valid_out && mac_tx_last_out && !mac_tx_abort_out |-> pos_q >= min_w; endproperty
  a_min: assert property (p_min) else $error("frame too short");
  property p_max; mac_tx_valid_out && pos_q >= lim_w |-> pos_q == lim_w && mac_tx_last_out && mac_tx_abort_out;
  endproperty
  a_max: assert property (p_max) else $error("frame too long");
  property p_abort; mac_tx_abort_out |-> mac_tx_valid_out && mac_tx_last_out; endproperty
  a_abort: assert property (p_abort) else $error("abort off last byte");
  property p_slow_dst; mac_tx_valid_out && variant_in && pos_q == 11'h000
    |-> mac_tx_data_out == (bc_w ? 8'h00 : tx_dst_ip_in[7:0] & host_mask_in[7:0]); endproperty
  a_slow_dst: assert property (p_slow_dst) else $error("bad slow dest");
  property p_rx_lat; rx_valid_out |-> $past(mac_rx_valid_in); endproperty
  a_rx_lat: assert property (p_rx_lat) else $error("rx byte without input");
  property p_rx_last; rx_last_out |-> rx_valid_out; endproperty
  a_rx_last: assert property (p_rx_last) else $error("last without byte");
  property p_drop; rx_drop_out |=> !rx_drop_out; endproperty
  a_drop: assert property (p_drop) else $error("drop pulse too long");
  property p_arp; arp_seen_out |-> !variant_in ##1 !arp_seen_out; endproperty
  a_arp: assert property (p_arp) else $error("bad query pulse");
endmodule // ipe_encap_chk
bind ipe_encap ipe_encap_chk #(.MIN_DATA_3M(MIN_DATA_3M), .FIFO_DEPTH(FIFO_DEPTH)) ipe_encap_chk_inst (
  .clk_in, .nrst_in, .variant_in, .host_mask_in, .tx_dst_ip_in, .mac_tx_data_out, .mac_tx_valid_out,
  .mac_tx_last_out, .mac_tx_abort_out, .mac_tx_ready_in, .mac_rx_valid_in, .rx_valid_out, .rx_last_out,
  .rx_drop_out, .arp_seen_out);
`default_nettype wire

// [testbench/ipe_mac_model.sv]
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// MAC side: takes bytes each cycle or every other one
module ipe_mac_model (
  input wire logic clk_in,
  input wire logic slow_in,
  output logic ready_out
);
  logic ph_q;
  initial ph_q = 1'b0;
  initial ready_out = 1'b1;
  // Half-rate stall keeps the FIFO filling up
  always @(posedge clk_in) begin
    ph_q <= ~ph_q;
    ready_out <= #1 !slow_in || ph_q;
  end
endmodule // ipe_mac_model
`default_nettype wire

// [testbench/tb.sv]
`timescale 1ns/1ns
`default_nettype none
module tb;
  import ipe_pkg::*;
  localparam logic [47:0] OWN_MAC = 48'h02A0B0C0D0E0;
  localparam logic [31:0] OWN_IP = 32'h0A000001;
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic slow = 1'b1;
  logic vsel = 1'b0; // Link variant under test, changed only while idle
  logic [31:0] dip = 32'h0A000005;
  logic [47:0] dmac = 48'h0A1B2C3D4E5F;
  logic [7:0] td = 8'h00, rd = 8'h00, md, rxd;
  logic tv = 1'b0, tl = 1'b0, rv = 1'b0, rl = 1'b0;
  logic trdy, mv, ml, ma, mrdy, rxv, rxl, drp, ovs, arp;
  logic [7:0] cap[$], ex[$], rxq[$], fq[$];
  int err_total = 0, comparisons = 0, fr = 0, drops = 0, ovc = 0, arps = 0, abc = 0, rlast = 0;
  always #50 clk_in = ~clk_in;
  ipe_encap ipe_encap_inst (.clk_in(clk_in), .nrst_in(nrst_in), .variant_in(vsel), .own_mac_in(OWN_MAC),
    .own_ip_in(OWN_IP), .host_mask_in(32'h000000FF), .tx_dst_ip_in(dip), .tx_dst_mac_in(dmac), .tx_data_in(td),
    .tx_valid_in(tv), .tx_last_in(tl), .tx_ready_out(trdy), .mac_tx_data_out(md), .mac_tx_valid_out(mv),
    .mac_tx_last_out(ml), .mac_tx_abort_out(ma), .mac_tx_ready_in(mrdy), .mac_rx_data_in(rd),
    .mac_rx_valid_in(rv), .mac_rx_last_in(rl), .rx_data_out(rxd), .rx_valid_out(rxv), .rx_last_out(rxl),
    .rx_drop_out(drp), .tx_oversize_out(ovs), .arp_seen_out(arp));
  ipe_mac_model ipe_mac_model_inst (.clk_in(clk_in), .slow_in(slow), .ready_out(mrdy));
  // Record everything the block hands out
  always @(posedge clk_in) begin
    if (mv && mrdy) begin
      cap.push_back(md);
      fr += ml;
      abc += ma;
    end
    if (rxv) begin
      rxq.push_back(rxd);
      if (rxl) rlast = rxq.size();
    end
    drops += drp;
    ovc += ovs;
    arps += arp;
  end
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("errors=%0d comparisons=%0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Datagram byte: IP header start, length, then counting
  function automatic logic [7:0] db(input int i, input int n);
    case (i)
      0: db = 8'h45;
      2: db = n[15:8];
      3: db = n[7:0];
      default: db = i[7:0];
    endcase
  endfunction
  task automatic put(input logic [47:0] v, input int nb);
    for (int k = nb - 1; k >= 0; k--) ex.push_back(v[8*k +: 8]);
  endtask
  task automatic zeros(input int nb);
    for (int k = 0; k < nb; k++) ex.push_back(8'h00);
  endtask
  task automatic hdr(input logic [47:0] dst, input logic [15:0] ty);
    put(dst, 6);
    put(OWN_MAC, 6);
    put(48'(ty), 2);
  endtask
  task automatic exp_ip(input logic [47:0] dst, input int n);
    hdr(dst, IPE_TYPE_IP_10M);
    for (int k = 0; k < n && k < 1500; k++) ex.push_back(db(k, n));
    if (n < 46) zeros(46 - n);
    if (n > 1500) zeros(1);
  endtask
  // Slow link frame: byte address, own low byte, type, data, pad
  task automatic exp_slow(input logic [7:0] dst, input int n);
    put(48'(dst), 1);
    put(OWN_MAC, 1);
    put(48'h000000000201, 2);
    for (int k = 0; k < n; k++) ex.push_back(db(k, n));
    // pad to the slow minimum of 46
    if (n < 46) zeros(46 - n);
  endtask
  task automatic send(input int n);
    int w;
    for (int k = 0; k < n; k++) begin
      td = db(k, n);
      tv = 1'b1;
      tl = (k == n - 1);
      w = 0;
      do begin
        @(posedge clk_in);
        w++;
      end while (trdy !== 1'b1 && w < 200);
      #1;
      if (w >= 200) begin
        err_total++;
        close_out();
      end
    end
    tv = 1'b0;
    tl = 1'b0;
  endtask
  task automatic wait_fr(input int n);
    int w = 0;
    while (fr < n && w < 4000) begin
      @(posedge clk_in);
      w++;
    end
    repeat (2) @(posedge clk_in);
    #1;
    if (fr < n) begin
      err_total++;
      close_out();
    end
  endtask
  task automatic cmp_cap();
    chk(cap.size(), ex.size());
    for (int k = 0; k < ex.size() && k < cap.size(); k++) chk(cap[k], ex[k]);
    cap.delete();
    ex.delete();
  endtask
  task automatic rxsend();
    fq = ex;
    ex.delete();
    for (int k = 0; k < fq.size(); k++) begin
      rd = fq[k];
      rv = 1'b1;
      rl = (k == fq.size() - 1);
      @(posedge clk_in);
      #1;
    end
    rv = 1'b0;
    rl = 1'b0;
    repeat (3) @(posedge clk_in);
    #1;
  endtask
  // Short datagram while the MAC stalls, FIFO fills up
  task automatic t_short();
    chk(trdy, 1'b1);
    exp_ip(dmac, 20);
    send(20);
    wait_fr(1);
    cmp_cap();
    slow = 1'b0;
  endtask
  // Broadcast destination, no pad needed
  task automatic t_bcast();
    dip = 32'h0A0000FF;
    exp_ip(IPE_BCAST_10M, 50);
    send(50);
    wait_fr(2);
    cmp_cap();
    dip = 32'h0A000005;
  endtask
  // One octet past the limit is cut off and flagged
  task automatic t_over();
    exp_ip(dmac, 1501);
    send(1501);
    wait_fr(3);
    chk(ovc, 1);
    chk(abc, 1);
    cmp_cap();
  endtask
  // Padded IP frame, then a foreign type
  task automatic t_rx();
    hdr(OWN_MAC, IPE_TYPE_IP_10M);
    for (int k = 0; k < 46; k++) ex.push_back(k < 20 ? db(k, 20) : 8'h00);
    rxsend();
    chk(rxq.size(), 20);
    chk(rlast, 20);
    for (int k = 0; k < 20; k++) chk(rxq[k], db(k, 20));
    rxq.delete();
    hdr(OWN_MAC, 16'h86DD);
    zeros(46);
    rxsend();
    chk(drops, 1);
    chk(rxq.size(), 0);
  endtask
  // Address query for our own address gets a reply
  task automatic t_arp();
    logic [47:0] sha = 48'h0E1D2C3B4A59;
    logic [31:0] spa = 32'h0A000009;
    hdr(IPE_BCAST_10M, IPE_TYPE_ARP);
    put(48'h000108000604, 6);
    put(48'(IPE_ARP_OP_REQ), 2);
    put(sha, 6);
    put(48'(spa), 4);
    put(48'h0, 6);
    put(48'(OWN_IP), 4);
    zeros(18);
    rxsend();
    chk(arps, 1);
    hdr(sha, IPE_TYPE_ARP);
    put(48'h000108000604, 6);
    put(48'(IPE_ARP_OP_REP), 2);
    put(OWN_MAC, 6);
    put(48'(OWN_IP), 4);
    put(sha, 6);
    put(48'(spa), 4);
    zeros(18);
    wait_fr(4);
    cmp_cap();
  endtask
  // Slow link: byte address, broadcast to zero, receive filter
  task automatic t_slow();
    vsel = 1'b1;
    exp_slow(8'h05, 20);
    send(20);
    wait_fr(5);
    cmp_cap();
    dip = 32'h0A0000FF;
    exp_slow(8'h00, 50);
    send(50);
    wait_fr(6);
    cmp_cap();
    dip = 32'h0A000005;
    rxq.delete();
    put(48'h0000E0050201, 4);
    for (int k = 0; k < 46; k++) ex.push_back(k < 20 ? db(k, 20) : 8'h00);
    rxsend();
    chk(rxq.size(), 20);
    chk(rlast, 20);
    // Query type is foreign on the slow link
    put(48'h0000E0050806, 4);
    zeros(46);
    rxsend();
    chk(drops, 2);
    chk(arps, 1);
  endtask
  initial begin
    repeat (10) @(posedge clk_in);
    #1;
    nrst_in = 1'b1;
    t_short();
    t_bcast();
    t_over();
    t_rx();
    t_arp();
    t_slow();
    close_out();
  end
endmodule // tb
`default_nettype wire
